//--- common/serial_rx_status_params.svh
// Register offsets, field positions and reset values of the serial status block
`ifndef SERIAL_RX_STATUS_PARAMS_SVH
`define SERIAL_RX_STATUS_PARAMS_SVH
// Register indices (byte offsets are the index times four)
`define SNAP_REQUEST_IDX 12'h120
`define SNAP_DONE_IDX 12'h121
`define X86_STATUS_IDX 12'h122
`define X86_IRQ_EN_IDX 12'h123
`define LOW_WM_IDX 12'h124
`define HIGH_WM_IDX 12'h125
`define QUEUE_IRQ_EN_IDX 12'h126
`define QUEUE_STATUS_IDX 12'h127
// Field positions
`define SAPI_HIGH_BIT 3
`define SAPI_LOW_BIT 2
`define CONTROL_BIT 1
`define ADDRESS_BIT 0
`define FIFO_OVF_BIT 3
`define QUEUE_OVF_BIT 2
`define HIGH_CROSS_BIT 1
`define LOW_CROSS_BIT 0
// Reset values
`define FLAGS_RESET 4'h0
`define BYTE_RESET 8'h00
// Watermark scaling: 32 packets of 2048 bytes, as a left shift
`define WM_PACKETS 32
`define WM_PACKET_BYTES 2048
`define WM_SHIFT 16
`endif

//--- common/serial_rx_status_pkg.sv
// Types of the serial status block
package serial_rx_status_pkg;
  typedef struct packed {
    logic [7:0] sapi_high;
    logic [7:0] sapi_low;
    logic [7:0] control;
    logic [7:0] address;
    logic valid;
  } x86_header_type;

  typedef struct packed {
    logic fifo_overflow;
    logic queue_overflow;
    logic [23:0] fill_level;
  } queue_event_type;

  typedef struct packed {
    logic snapshot_request;
    logic snapshot_done;
    logic snapshot_busy;
    logic [3:0] x86_flags;
    logic [3:0] x86_irq_en;
    logic [7:0] low_wm;
    logic [7:0] high_wm;
    logic [3:0] queue_irq_en;
    logic [3:0] queue_flags;
    logic above_low;
    logic above_high;
    logic ready_out;
    logic [31:0] rdata;
    logic dphase;
    logic dwrite;
    logic [11:0] dindex;
  } state_type;
endpackage

//--- design/serial_rx_status_watermark_regs.sv
// Serial side status, watermark and interrupt registers on AHB-Lite
`timescale 1ns/1ps
`include "serial_rx_status_params.svh"
module serial_rx_status_watermark_regs
  import serial_rx_status_pkg::*;
#(
  parameter int FILL_WIDTH = 24
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire x86_header_type expected_i,
  input wire x86_header_type received_i,
  input wire queue_event_type queue_i,
  input wire logic snapshot_complete_i,
  output logic snapshot_start_o,
  output logic irq_o
);

  // Elaboration check: the fill width must hold a scaled 8-bit threshold
  if (FILL_WIDTH < `WM_SHIFT + 8 || FILL_WIDTH > 24)
  begin : g_bad_fill_width
    $error("FILL_WIDTH must be 24");
  end

  state_type s_reg;
  state_type s_next;
  logic [FILL_WIDTH-1:0] low_pos;
  logic [FILL_WIDTH-1:0] high_pos;
  logic [FILL_WIDTH-1:0] fill;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [FILL_WIDTH-1:0] wm_position(input logic [7:0] value);
    wm_position = FILL_WIDTH'({value, 16'h0000});
  endfunction

  function automatic logic [31:0] read_value(input state_type s, input logic [11:0] idx);
    if (idx == `SNAP_REQUEST_IDX)
      read_value = {31'h0, s.snapshot_request};
    else if (idx == `SNAP_DONE_IDX)
      read_value = {31'h0, s.snapshot_done};
    else if (idx == `X86_STATUS_IDX)
      read_value = {28'h0, s.x86_flags};
    else if (idx == `X86_IRQ_EN_IDX)
      read_value = {28'h0, s.x86_irq_en};
    else if (idx == `LOW_WM_IDX)
      read_value = {24'h0, s.low_wm};
    else if (idx == `HIGH_WM_IDX)
      read_value = {24'h0, s.high_wm};
    else if (idx == `QUEUE_IRQ_EN_IDX)
      read_value = {28'h0, s.queue_irq_en};
    else if (idx == `QUEUE_STATUS_IDX)
      read_value = {28'h0, s.queue_flags};
    else
      read_value = 32'h0;
  endfunction

  assign fill = queue_i.fill_level[FILL_WIDTH-1:0];
  assign low_pos = wm_position(s_reg.low_wm);
  assign high_pos = wm_position(s_reg.high_wm);

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    logic [3:0] x86_set;
    logic [3:0] q_set;
    logic now_low;
    logic now_high;
    logic take;
    logic [11:0] idx;
    x86_set = 4'h0;
    q_set = 4'h0;
    s_next = s_reg;
    idx = haddr_i[13:2];
    take = hsel_i && hready_i && htrans_i[1];
    now_low = fill >= low_pos;
    now_high = fill >= high_pos;
    s_next.above_low = now_low;
    s_next.above_high = now_high;
    s_next.ready_out = 1'b1;
    // Header comparison events
    if (received_i.valid)
    begin
      x86_set[`SAPI_HIGH_BIT] = received_i.sapi_high != expected_i.sapi_high;
      x86_set[`SAPI_LOW_BIT] = received_i.sapi_low != expected_i.sapi_low;
      x86_set[`CONTROL_BIT] = received_i.control != expected_i.control;
      x86_set[`ADDRESS_BIT] = received_i.address != expected_i.address;
    end
    // Queue events
    q_set[`FIFO_OVF_BIT] = queue_i.fifo_overflow;
    q_set[`QUEUE_OVF_BIT] = queue_i.queue_overflow;
    q_set[`HIGH_CROSS_BIT] = now_high != s_reg.above_high;
    q_set[`LOW_CROSS_BIT] = now_low != s_reg.above_low;
    // Data phase of the previous transfer
    if (s_reg.dphase)
    begin
      if (s_reg.dwrite)
      begin
        if (s_reg.dindex == `SNAP_REQUEST_IDX)
        begin
          s_next.snapshot_request = hwdata_i[0];
          if (!hwdata_i[0])
          begin
            s_next.snapshot_done = 1'b0;
            s_next.snapshot_busy = 1'b0;
          end
          else if (!s_reg.snapshot_request)
            s_next.snapshot_busy = 1'b1;
        end
        else if (s_reg.dindex == `X86_IRQ_EN_IDX)
          s_next.x86_irq_en = hwdata_i[3:0];
        else if (s_reg.dindex == `LOW_WM_IDX)
          s_next.low_wm = hwdata_i[7:0];
        else if (s_reg.dindex == `HIGH_WM_IDX)
          s_next.high_wm = hwdata_i[7:0];
        else if (s_reg.dindex == `QUEUE_IRQ_EN_IDX)
          s_next.queue_irq_en = hwdata_i[3:0];
      end
      else if (s_reg.dindex == `X86_STATUS_IDX)
        s_next.x86_flags = `FLAGS_RESET;
      else if (s_reg.dindex == `QUEUE_STATUS_IDX)
        s_next.queue_flags = `FLAGS_RESET;
    end
    // Set wins over the read clear
    s_next.x86_flags = s_next.x86_flags | x86_set;
    s_next.queue_flags = s_next.queue_flags | q_set;
    if (s_reg.snapshot_busy && snapshot_complete_i && s_next.snapshot_request)
    begin
      s_next.snapshot_done = 1'b1;
      s_next.snapshot_busy = 1'b0;
    end
    // Address phase
    s_next.dphase = take;
    s_next.dwrite = hwrite_i;
    s_next.dindex = idx;
    if (take && !hwrite_i)
      s_next.rdata = read_value(s_reg, idx);
    else if (s_reg.dphase)
      s_next.rdata = 32'h0;
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.ready_out <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign hreadyout_o = s_reg.ready_out;
  assign hresp_o = 1'b0;
  assign hrdata_o = s_reg.rdata;
  assign snapshot_start_o = s_next.snapshot_busy && !s_reg.snapshot_busy;
  assign irq_o = |(s_reg.x86_flags & s_reg.x86_irq_en) || |(s_reg.queue_flags & s_reg.queue_irq_en);
endmodule

//--- bench/serial_rx_status_properties.sv
// Concurrent checks on the serial status register block ports
`timescale 1ns/1ps
module serial_rx_status_props (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic snapshot_start_o,
  input wire logic irq_o
);
  wire req = hsel_i && hready_i && htrans_i[1];
  wire rd = req && !hwrite_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence read_s(a);
    rd && haddr_i == a;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  snap_start_a: assert property (snapshot_start_o |->
    $past(req && hwrite_i && haddr_i == 32'h480) && hwdata_i[0]) else $error("stray snapshot start");
  snap_pulse_a: assert property (snapshot_start_o |=> !snapshot_start_o)
    else $error("snapshot start too long");
  idle_data_a: assert property (!$past(rd) |-> hrdata_o == 32'h0)
    else $error("read data outside data phase");
  unmapped_rd_a: assert property (read_s(32'h4a0) |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd |=> hrdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  flag_width_a: assert property (rd && haddr_i != 32'h490 && haddr_i != 32'h494 |=> hrdata_o[31:4] == 28'h0)
    else $error("flag register upper bits set");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(hsel_i && htrans_i[1], 2) || $past(hsel_i && htrans_i[1], 3))
    else $error("interrupt dropped without access");
  ready_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("wait state or error response");
endmodule
bind serial_rx_status_watermark_regs serial_rx_status_props u_props (.clk_sys_i, .rst_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .snapshot_start_o, .irq_o);

//--- bench/serial_rx_status_watermark_regs_tb.sv
// Testbench of the serial status register block
`timescale 1ns/1ps
module serial_rx_status_watermark_regs_tb;
  import serial_rx_status_pkg::*;
  localparam logic [31:0] B = 32'h480;
  logic clk_sys_i = 1'h0, rst_i = 1'h1, hsel = 1'h0, hwrite = 1'h0, cmpl = 1'h0, rdy, resp, start, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, fails = 32'h0, comparisons = 32'h0, starts = 32'h0;
  x86_header_type ex = 33'h1_4b86_78b4, rx = 33'h0;
  queue_event_type q = 26'h0;
  serial_rx_status_watermark_regs dut (.clk_sys_i, .rst_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy), .hreadyout_o(rdy), .hresp_o(resp),
    .hrdata_o(hrdata), .expected_i(ex), .received_i(rx), .queue_i(q), .snapshot_complete_i(cmpl),
    .snapshot_start_o(start), .irq_o(irq));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (start === 1'h1) starts <= starts + 32'h1;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys_i);
    hsel <= 1'h1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge clk_sys_i); while (rdy !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk_sys_i); while (rdy !== 1'h1);
    r = hrdata;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask
  task irq_is(input logic e);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 32'h0 && comparisons > 32'h0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    for (int i = 0; i < 7; i++) rd(B + 4 * i, 32'h0);
    rd(B + 32'h1c, 32'h3);
    rd(B + 32'h1c, 32'h0);
    $display("reset test done");
  endtask
  task t_regs;
    wr(B + 32'hc, 32'hff);
    rd(B + 32'hc, 32'hf);
    wr(B + 32'h10, 32'h1ff);
    rd(B + 32'h10, 32'hff);
    wr(B + 32'h20, 32'hff);
    rd(B + 32'h20, 32'h0);
    wr(B + 32'h8, 32'hf);
    rd(B + 32'h8, 32'h0);
    $display("register test done");
  endtask
  task t_snap;
    wr(B, 32'h1);
    @(negedge clk_sys_i);
    chk(starts, 32'h1);
    rd(B + 32'h4, 32'h0);
    @(posedge clk_sys_i) cmpl <= 1'h1;
    @(posedge clk_sys_i) cmpl <= 1'h0;
    rd(B + 32'h4, 32'h1);
    wr(B, 32'h0);
    rd(B + 32'h4, 32'h0);
    $display("snapshot test done");
  endtask
  task t_x86;
    for (int i = 0; i < 4; i++)
    begin
      wr(B + 32'hc, 32'h1 << i);
      @(posedge clk_sys_i) rx <= x86_header_type'((ex ^ (33'h1 << (1 + 8 * i))) | 33'h1);
      @(posedge clk_sys_i) rx.valid <= 1'h0;
      irq_is(1'h1);
      rd(B + 32'h8, 32'h1 << i);
      irq_is(1'h0);
      rd(B + 32'h8, 32'h0);
    end
    wr(B + 32'hc, 32'h0);
    $display("header test done");
  endtask
  task t_queue;
    wr(B + 32'h10, 32'h1);
    wr(B + 32'h14, 32'h2);
    rd(B + 32'h1c, 32'h3);
    @(posedge clk_sys_i) q.fill_level <= 24'h010000;
    rd(B + 32'h1c, 32'h1);
    @(posedge clk_sys_i) q.fill_level <= 24'h01ffff;
    rd(B + 32'h1c, 32'h0);
    @(posedge clk_sys_i) q.fill_level <= 24'h020000;
    rd(B + 32'h1c, 32'h2);
    @(posedge clk_sys_i) q <= 26'h3020000;
    @(posedge clk_sys_i) q <= 26'h0020000;
    irq_is(1'h0);
    wr(B + 32'h18, 32'h4);
    irq_is(1'h1);
    rd(B + 32'h1c, 32'hc);
    irq_is(1'h0);
    $display("queue test done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    t_reset;
    t_regs;
    t_snap;
    t_x86;
    t_queue;
    close_out;
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    fails++;
    close_out;
  end
endmodule
